// ==== rtl/xdc_engine.sv ====
// cross-domain compare engine: apb registers, decode and byte-serial compare
// How it works
// - opcode 0x25 compares first source region against second over transfer size.
// - flag 17 set uses second-source handle's space; clear ignores it.
// - flag 16 set uses first-source handle's space; clear ignores it.
// - two-source result and status reported like an ordinary compare.
// - opcode 0x26 compares source region against the inline pattern.
// - pattern interpreted and results reported as ordinary pattern compare.
// - check-result flag and expected result handled as ordinary compare.
// - completion word: status byte 0, result byte 1; bytes completed in the next word (CR1).
`timescale 1ns/1ps
module xdc_engine
  import xdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_alt_space,
  output logic [15:0] permission_entry_handle,
  input wire logic mem_ack,
  input wire logic mem_fault,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic irq
);
  // ==========================================================================
  // register storage
  logic [31:0] opflags_reg;
  logic [31:0] size_reg;
  logic [31:0] first_source_pointer;
  logic [31:0] second_source_pointer;
  logic [31:0] pattern_reg;
  logic [31:0] handles_reg;
  logic [7:0] expect_reg;
  logic check_reg;
  logic [7:0] status_reg;
  logic [7:0] result_reg;
  logic [31:0] done_cnt_reg;
  logic [31:0] fault_addr_reg;
  logic [15:0] fault_handle_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  xdc_state_t state_reg;
  logic phase_reg;
  logic [7:0] byte1_reg;
  logic [31:0] idx_reg;
  logic wr_en;
  logic start;
  logic ev_done;
  logic ev_fault;
  logic [7:0] opcode;
  logic first_source_alt_space_flag;
  logic second_source_alt_space_flag;
  logic two_src;
  logic flags_ok;
  logic [7:0] pat_byte;
  logic [7:0] operand_b;
  logic last;

  assign opcode = opflags_reg[31:24];
  assign first_source_alt_space_flag = opflags_reg[FLAG_SRC1_ALT];
  assign second_source_alt_space_flag = opflags_reg[FLAG_SRC2_ALT];
  assign two_src = (opcode == OP_XCMP);
  // reserved flag checks; status reports violations by software
  logic resv_two_ok;
  logic resv_pat_ok;
  logic alt_any;
  assign resv_two_ok = (opflags_reg[23:18] == 6'h00);
  assign resv_pat_ok = (opflags_reg[23:17] == 7'h00);
  assign alt_any = first_source_alt_space_flag | second_source_alt_space_flag;
  assign flags_ok = two_src ? (resv_two_ok && alt_any)
                            : (resv_pat_ok && first_source_alt_space_flag);

  // ==========================================================================
  // apb slave: zero-wait, error on unmapped address
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign start = wr_en && paddr == A_CTRL && pwdata[CTRL_START] && state_reg == XDC_IDLE;
  assign busy = (state_reg != XDC_IDLE);

  // descriptor writes are dropped while a compare runs
  logic desc_wr;
  assign desc_wr = wr_en && !busy;

  // operation word, check-result flag and expected result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opflags_reg <= 32'h00000000;
      check_reg <= 1'b0;
      expect_reg <= 8'h00;
    end else if (desc_wr) begin
      case (paddr)
        A_CTRL: check_reg <= pwdata[CTRL_CHECK];
        A_OPFLAGS: opflags_reg <= pwdata;
        A_EXPECT: expect_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // transfer size and the two source pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_reg <= 32'h00000000;
      first_source_pointer <= 32'h00000000;
      second_source_pointer <= 32'h00000000;
    end else if (desc_wr) begin
      case (paddr)
        A_SIZE: size_reg <= pwdata;
        A_SRC1: first_source_pointer <= pwdata;
        A_SRC2: second_source_pointer <= pwdata;
        default: ;
      endcase
    end
  end

  // inline pattern and the pair of permission handles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_reg <= 32'h00000000;
      handles_reg <= 32'h00000000;
    end else if (desc_wr) begin
      case (paddr)
        A_PATTERN: pattern_reg <= pwdata;
        A_HANDLES: handles_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // interrupt mask stays writable while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_en && paddr == A_IRQ_MASK) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end

  // read mux and error response
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      A_CTRL: prdata = {30'h00000000, check_reg, busy};
      A_OPFLAGS: prdata = opflags_reg;
      A_SIZE: prdata = size_reg;
      A_SRC1: prdata = first_source_pointer;
      A_SRC2: prdata = second_source_pointer;
      A_PATTERN: prdata = pattern_reg;
      A_HANDLES: prdata = handles_reg;
      A_EXPECT: prdata = {24'h000000, expect_reg};
      A_CR0: prdata = {16'h0000, result_reg, status_reg};
      A_CR1: prdata = done_cnt_reg;
      A_FAULT_ADDR: prdata = fault_addr_reg;
      A_FAULT_HANDLE: prdata = {16'h0000, fault_handle_reg};
      A_IRQ_STATUS: prdata = {30'h00000000, irq_status_reg};
      A_IRQ_MASK: prdata = {30'h00000000, irq_mask_reg};
      default: pslverr = psel & penable;
    endcase
  end

  // ==========================================================================
  // memory request: alternate space and handle chosen per source
  assign pat_byte = pattern_reg[8*idx_reg[1:0] +: 8];
  assign operand_b = two_src ? mem_rdata : pat_byte;
  assign last = (idx_reg + 32'h00000001 >= size_reg);
  assign mem_req = (state_reg == XDC_REQ);

  always_comb begin
    mem_addr = first_source_pointer + idx_reg;
    mem_alt_space = first_source_alt_space_flag;
    permission_entry_handle = first_source_alt_space_flag ? handles_reg[15:0] : 16'h0000;
    if (phase_reg) begin
      mem_addr = second_source_pointer + idx_reg;
      mem_alt_space = second_source_alt_space_flag;
      permission_entry_handle = second_source_alt_space_flag ? handles_reg[31:16] : 16'h0000;
    end
  end

  // ==========================================================================
  // compare sequencer: events that steer every register below
  logic op_known;
  logic bad_op;
  logic bad_flags;
  logic empty_xfer;
  logic in_wait;
  logic got_fault;
  logic got_byte;
  logic first_half;
  logic byte_pair_done;
  logic differs;
  logic finish_diff;
  logic finish_all;
  logic step_next;
  logic [7:0] chk_byte;

  // start-time decode: refused descriptors finish at once
  assign op_known = (opcode == OP_XCMP) || (opcode == OP_XCMP_PAT);
  assign bad_op = start && !op_known;
  assign bad_flags = start && op_known && !flags_ok;
  assign empty_xfer = start && op_known && flags_ok && (size_reg == 32'h00000000);

  // answer-time decode: the fault or byte that ends each wait
  assign in_wait = (state_reg == XDC_WAIT);
  assign got_fault = in_wait && mem_fault;
  assign got_byte = in_wait && !mem_fault && mem_ack;
  assign first_half = got_byte && two_src && !phase_reg;
  assign byte_pair_done = got_byte && !(two_src && !phase_reg);
  assign chk_byte = two_src ? byte1_reg : mem_rdata;
  assign differs = (chk_byte != operand_b);
  assign finish_diff = byte_pair_done && differs;
  assign finish_all = byte_pair_done && !differs && last;
  assign step_next = byte_pair_done && !differs && !last;

  // state walk: request, wait for the answer, one done cycle, then idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= XDC_IDLE;
    end else begin
      case (state_reg)
        XDC_IDLE: begin
          if (bad_op || bad_flags || empty_xfer) begin
            state_reg <= XDC_DONE;
          end else if (start) begin
            state_reg <= XDC_REQ;
          end
        end
        XDC_REQ: state_reg <= XDC_WAIT;
        XDC_WAIT: begin
          if (got_fault || finish_diff || finish_all) begin
            state_reg <= XDC_DONE;
          end else if (first_half || step_next) begin
            state_reg <= XDC_REQ;
          end
        end
        XDC_DONE: state_reg <= XDC_IDLE;
        default: state_reg <= XDC_IDLE;
      endcase
    end
  end

  // byte index and which source the next request reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_reg <= 32'h00000000;
      phase_reg <= 1'b0;
    end else if (start) begin
      idx_reg <= 32'h00000000;
      phase_reg <= 1'b0;
    end else if (first_half) begin
      phase_reg <= 1'b1;
    end else if (byte_pair_done) begin
      phase_reg <= 1'b0;
      if (step_next) begin
        idx_reg <= idx_reg + 32'h00000001;
      end
    end
  end

  // first-source byte held until its partner arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte1_reg <= 8'h00;
    end else if (first_half) begin
      byte1_reg <= mem_rdata;
    end
  end

  // completion word: status, result and bytes completed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 8'h00;
      result_reg <= 8'h00;
      done_cnt_reg <= 32'h00000000;
    end else if (start) begin
      result_reg <= 8'h00;
      done_cnt_reg <= 32'h00000000;
      if (bad_op) begin
        status_reg <= ST_BAD_OPCODE;
      end else if (bad_flags) begin
        status_reg <= ST_BAD_FLAGS;
      end else if (empty_xfer) begin
        status_reg <= ST_SUCCESS;
      end
    end else if (got_fault) begin
      status_reg <= ST_PAGE_FAULT;
      done_cnt_reg <= idx_reg;
    end else if (finish_diff) begin
      result_reg <= 8'h01;
      done_cnt_reg <= idx_reg;
      status_reg <= (check_reg && expect_reg != 8'h01) ? ST_FALSE_PRED : ST_SUCCESS;
    end else if (finish_all) begin
      done_cnt_reg <= size_reg;
      status_reg <= (check_reg && expect_reg != 8'h00) ? ST_FALSE_PRED : ST_SUCCESS;
    end
  end

  // fault record: the access that faulted and the handle it went out under
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_addr_reg <= 32'h00000000;
      fault_handle_reg <= 16'h0000;
    end else if (got_fault) begin
      fault_addr_reg <= mem_addr;
      fault_handle_reg <= permission_entry_handle;
    end
  end

  // ==========================================================================
  // interrupts: sticky status, write one to clear, set wins
  logic [1:0] irq_event;
  logic [1:0] irq_clear;
  assign ev_done = (state_reg == XDC_DONE);
  assign ev_fault = ev_done && status_reg == ST_PAGE_FAULT;
  assign irq_event[IRQ_DONE] = ev_done;
  assign irq_event[IRQ_FAULT] = ev_fault;
  assign irq_clear = (wr_en && paddr == A_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

  // one sticky bit per event; a clear in the same cycle loses
  for (genvar g = 0; g < $bits(irq_status_reg); g++) begin : g_irq_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_status_reg[g] <= 1'b0;
      end else begin
        irq_status_reg[g] <= irq_event[g] | (irq_status_reg[g] & ~irq_clear[g]);
      end
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(irq_status_reg & irq_mask_reg);
endmodule

// ==== rtl/xdc_pkg.sv ====
// package of constants for the cross-domain compare engine
package xdc_pkg;
  // ==========================================================================
  // operation codes and flag positions
  localparam logic [7:0] OP_XCMP = 8'h25;
  localparam logic [7:0] OP_XCMP_PAT = 8'h26;
  localparam int FLAG_SRC1_ALT = 16;
  localparam int FLAG_SRC2_ALT = 17;
  // ==========================================================================
  // completion status codes
  localparam logic [7:0] ST_SUCCESS = 8'h01;
  localparam logic [7:0] ST_PAGE_FAULT = 8'h03;
  localparam logic [7:0] ST_FALSE_PRED = 8'h02;
  localparam logic [7:0] ST_BAD_OPCODE = 8'h10;
  localparam logic [7:0] ST_BAD_FLAGS = 8'h11;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OPFLAGS = 8'h04;
  localparam logic [7:0] A_SIZE = 8'h08;
  localparam logic [7:0] A_SRC1 = 8'h0C;
  localparam logic [7:0] A_SRC2 = 8'h10;
  localparam logic [7:0] A_PATTERN = 8'h14;
  localparam logic [7:0] A_HANDLES = 8'h18;
  localparam logic [7:0] A_EXPECT = 8'h1C;
  localparam logic [7:0] A_CR0 = 8'h20;
  localparam logic [7:0] A_CR1 = 8'h24;
  localparam logic [7:0] A_FAULT_ADDR = 8'h28;
  localparam logic [7:0] A_FAULT_HANDLE = 8'h2C;
  localparam logic [7:0] A_IRQ_STATUS = 8'h30;
  localparam logic [7:0] A_IRQ_MASK = 8'h34;
  // ==========================================================================
  // field positions and reset values
  localparam int CTRL_START = 0;
  localparam int CTRL_CHECK = 1;
  localparam int CR_RESULT_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  typedef enum logic [1:0] {XDC_IDLE, XDC_REQ, XDC_WAIT, XDC_DONE} xdc_state_t;
endpackage

// ==== tb/xdc_engine_assertions.sv ====
// port checker for the cross-domain compare engine
`timescale 1ns/1ps
module xdc_engine_assertions
  import xdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_alt_space,
  input wire logic [15:0] permission_entry_handle,
  input wire logic mem_ack,
  input wire logic mem_fault,
  input wire logic busy
);
  // ==========================================================================
  // access and completion checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_req_single: assert property (mem_req |=> !mem_req)
    else $error("memory request wider than one cycle");
  a_req_busy: assert property (mem_req |-> busy)
    else $error("memory request while idle");
  a_ack_apart: assert property (mem_ack |-> !mem_req)
    else $error("new request while an access is pending");
  a_access_held: assert property (mem_req |=> $stable(mem_addr) && $stable(mem_alt_space)
    && $stable(permission_entry_handle)) else $error("access qualifiers moved");
  a_handle_unused: assert property (mem_req && !mem_alt_space |->
    permission_entry_handle == 16'h0000) else $error("handle used with flag clear");
  a_fault_ends: assert property (mem_fault |=> !mem_req [*2])
    else $error("access continued after fault");
  a_zero_wait: assert property (psel |-> pready)
    else $error("bus access not zero wait");
  a_unmapped_err: assert property (psel && penable && paddr > A_IRQ_MASK |-> pslverr)
    else $error("unmapped access without error");
  cover property (mem_req && mem_alt_space);
  cover property (mem_fault);
  cover property ($fell(busy));
endmodule

// ==== tb/xdc_mem_model.sv ====
// system memory model: byte is address plus handle low byte in an alternate space
`timescale 1ns/1ps
module xdc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_alt_space,
  input wire logic [15:0] permission_entry_handle,
  input wire logic slow,
  input wire logic [31:0] fault_addr,
  output logic mem_ack,
  output logic mem_fault,
  output logic [7:0] mem_rdata
);
  logic pend_reg;
  logic flt_reg;
  logic [2:0] cnt_reg;
  logic [7:0] val_reg;
  // every handle names a permitted entry; its space offsets the data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      mem_rdata <= ~mem_rdata; // released data never holds
      if (mem_req) begin
        pend_reg <= 1'b1;
        cnt_reg <= slow ? 3'h3 : 3'h0;
        flt_reg <= mem_addr == fault_addr;
        val_reg <= mem_addr[7:0] + (mem_alt_space ? permission_entry_handle[7:0] : 8'h00);
      end else if (pend_reg && cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
      end else if (pend_reg) begin
        pend_reg <= 1'b0;
        mem_fault <= flt_reg;
        mem_ack <= !flt_reg;
        mem_rdata <= val_reg;
      end
    end
  end
endmodule

// ==== tb/xdc_engine_tb_top.sv ====
// testbench for the cross-domain compare engine
`timescale 1ns/1ps
module xdc_engine_tb_top import xdc_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_alt_space;
  logic mem_ack, mem_fault, busy, irq, slow, err;
  logic [7:0] paddr, mem_rdata;
  logic [15:0] permission_entry_handle;
  logic [31:0] pwdata, prdata, mem_addr, fault_addr, rdv, r0, r1;
  int miscompares, cmp_count;
  logic [7:0] bad_op[5] = '{8'h25, 8'h25, 8'h26, 8'h26, 8'h24};
  logic [7:0] bad_fl[5] = '{8'h07, 8'h00, 8'h00, 8'h03, 8'h01};
  logic [7:0] bad_st[5] = '{ST_BAD_FLAGS, ST_BAD_FLAGS, ST_BAD_FLAGS, ST_BAD_FLAGS, ST_BAD_OPCODE};
  xdc_engine u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req, .mem_addr, .mem_alt_space, .permission_entry_handle,
    .mem_ack, .mem_fault, .mem_rdata, .busy, .irq);
  xdc_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_addr, .mem_alt_space,
    .permission_entry_handle, .slow, .fault_addr, .mem_ack, .mem_fault, .mem_rdata);
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // one apb transfer; data and error taken at the pready edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(logic [7:0] op, logic [7:0] fl, logic [31:0] sz, s1, s2, pat, hd,
      logic [1:0] ctl);
    apb(1'b1, A_OPFLAGS, {op, fl, 16'h0000});
    apb(1'b1, A_SIZE, sz);
    apb(1'b1, A_SRC1, s1);
    apb(1'b1, A_SRC2, s2);
    apb(1'b1, A_PATTERN, pat);
    apb(1'b1, A_HANDLES, hd);
    apb(1'b1, A_CTRL, {30'h0, ctl});
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
    apb(1'b0, A_CR0, 32'h0);
    r0 = rdv;
    apb(1'b0, A_CR1, 32'h0);
    r1 = rdv;
  endtask
  task automatic t_two_source();
    slow <= 1'b1;
    run(OP_XCMP, 8'h03, 32'h4, 32'h10, 32'h20, 32'h0, 32'h0000_0010, 2'h1);
    chk("cr0", r0[15:0], {8'h00, ST_SUCCESS});
    slow <= 1'b0;
    run(OP_XCMP, 8'h01, 32'h4, 32'h10, 32'h20, 32'h0, 32'h0005_0010, 2'h1);
    chk("result", r0[15:8], 8'h00);
    run(OP_XCMP, 8'h02, 32'h4, 32'h30, 32'h20, 32'h0, 32'h0010_0007, 2'h1);
    chk("result", r0[15:8], 8'h00);
    $display("two source done");
  endtask
  task automatic t_pattern();
    run(OP_XCMP_PAT, 8'h01, 32'h6, 32'h40, 32'h0, 32'h4342_4140, 32'h0, 2'h1);
    chk("cr0", r0[15:0], {8'h01, ST_SUCCESS});
    chk("completed", r1, 32'h4);
    run(OP_XCMP_PAT, 8'h01, 32'h6, 32'h40, 32'h0, 32'h4342_4140, 32'h0, 2'h3);
    chk("status", r0[7:0], ST_FALSE_PRED);
    run(OP_XCMP, 8'h03, 32'h4, 32'h10, 32'h20, 32'h0, 32'h0000_0010, 2'h3);
    chk("status", r0[7:0], ST_SUCCESS);
    apb(1'b1, A_EXPECT, 32'h1);
    run(OP_XCMP_PAT, 8'h01, 32'h6, 32'h40, 32'h0, 32'h4342_4140, 32'h0, 2'h3);
    chk("status", r0[7:0], ST_SUCCESS);
    run(OP_XCMP, 8'h03, 32'h4, 32'h10, 32'h20, 32'h0, 32'h0000_0010, 2'h3);
    chk("status", r0[7:0], ST_FALSE_PRED);
    apb(1'b1, A_EXPECT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      run(bad_op[i], bad_fl[i], 32'h4, 32'h10, 32'h20, 32'h0, 32'h0000_0010, 2'h1);
      chk("refused", r0[7:0], bad_st[i]);
    end
    $display("pattern done");
  endtask
  task automatic t_fault();
    fault_addr <= 32'h11;
    apb(1'b1, A_IRQ_STATUS, 32'h3);
    apb(1'b1, A_IRQ_MASK, 32'h3);
    run(OP_XCMP, 8'h03, 32'h4, 32'h10, 32'h20, 32'h0, 32'h0000_0010, 2'h1);
    chk("status", r0[7:0], ST_PAGE_FAULT);
    apb(1'b0, A_FAULT_ADDR, 32'h0);
    chk("fault addr", rdv, 32'h11);
    apb(1'b0, A_FAULT_HANDLE, 32'h0);
    chk("fault handle", rdv[15:0], 16'h0010);
    apb(1'b0, A_IRQ_STATUS, 32'h0);
    chk("irq status", rdv[1:0], 2'h3);
    chk("irq", irq, 1'b1);
    apb(1'b1, A_IRQ_STATUS, 32'h3);
    apb(1'b1, A_IRQ_MASK, 32'h0);
    fault_addr <= 32'hFFFF_FFFF;
    run(OP_XCMP, 8'h03, 32'h4, 32'h10, 32'h20, 32'h0, 32'h0000_0010, 2'h1);
    chk("masked irq", irq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", err, 1'b1);
    $display("fault done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, slow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_addr = 32'hFFFF_FFFF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_IRQ_MASK, 32'h0);
    chk("mask reset", rdv[1:0], IRQ_MASK_RST);
    t_two_source();
    t_pattern();
    t_fault();
    stop_test();
  end
endmodule
bind xdc_engine xdc_engine_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .mem_req, .mem_addr, .mem_alt_space, .permission_entry_handle,
  .mem_ack, .mem_fault, .busy);
